// file: verilog/tbm_master.sv
// Two-byte serial bus master with its special function registers.
// Assumes a 400 kHz time base clock from another domain and open-drain bus pads.
//
// What this block does
// - Acts only as bus master, serial clock at 400 kHz fast mode.
// - A frame carries one or two data bytes, read or write only.
// - Bit slots follow the 400 kHz time base clock; edges inside a slot are counted in processor clocks.
// - Raises completion interrupt on interrupt six line when a transaction finishes.
// - Completion interrupt drops automatically when the next transaction starts.
// - Address register: 7-bit peer address in bits 7..1, direction in bit 0.
// - A write sends the primary transmit byte first.
// - Writing 1 to control bit 1 starts bus activity, after address and data load.
// - Two-byte read with bit 0 set captures a second byte into secondary register.
// - After a two-byte read the second byte stays readable in secondary register.
// - Seven dedicated registers control the master.
// - Acknowledge error sets on a high peer acknowledge bit, clears at next start.
// - Start bit reads as busy, clears at finish; only the interrupt enable loads while busy.
`timescale 1ns/100ps
`include "tbm_consts.svh"

module tbm_master (
	input  wire logic            core_clk_i,
	input  wire logic            rst_b_i,
	input  wire logic            ce_i,
	input  wire logic [15:0]     sfr_addr_i,
	input  wire logic            sfr_wr_i,
	input  wire logic            sfr_rd_i,
	input  wire tbm_pkg::tbm_byte_t sfr_wdata_i,
	output tbm_pkg::tbm_byte_t   sfr_rdata_o,
	output logic                 irq6_o,
	input  wire logic            tb_400k_i,
	input  wire logic            scl_i,
	output logic                 scl_o,
	output logic                 scl_oe_o,
	input  wire logic            sda_i,
	output logic                 sda_o,
	output logic                 sda_oe_o
);
	import tbm_pkg::*;
	localparam logic [6:0] HALF      = 7'(`TBM_HALF_CYC);
	localparam logic [6:0] SDA_SET   = 7'(`TBM_SDA_SET_CYC);
	localparam logic [6:0] SAMPLE    = 7'(`TBM_SAMPLE_CYC);

	tbm_state_e state_ff;
	tbm_byte_t  peer_address_reg_ff;
	tbm_byte_t  primary_tx_byte_ff;
	tbm_byte_t  secondary_tx_byte_ff;
	tbm_byte_t  primary_rx_byte_ff;
	tbm_byte_t  secondary_rx_byte_ff;
	tbm_byte_t  rx_sh_ff;
	tbm_byte_t  cur_tx;
	logic       two_byte_select_ff;
	logic       go_busy_ff;
	logic       ack_error_flag_ff;
	logic       transfer_done_flag_ff;
	logic       transfer_done_irq_enable_ff;
	logic [6:0] ph_ff;
	logic [3:0] bit_idx_ff;
	logic [1:0] byte_idx_ff;
	logic [2:0] tb_sync_ff;
	logic [1:0] sda_sync_ff;
	logic [1:0] scl_sync_ff;
	logic       tick;
	logic       go_req;
	logic       wr_ok;
	logic       is_read;
	logic       last_byte;
	logic       byte_end;
	logic       nack_seen;

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Time base crossing; only the second and third stages feed the edge
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tb_sync_ff  <= 3'h0;
			sda_sync_ff <= 2'h3;
			scl_sync_ff <= 2'h3;
		end else if (ce_i) begin
			tb_sync_ff  <= {tb_sync_ff[1:0], tb_400k_i};
			sda_sync_ff <= {sda_sync_ff[0], sda_i};
			scl_sync_ff <= {scl_sync_ff[0], scl_i};
		end
	end
	assign tick = tb_sync_ff[1] & ~tb_sync_ff[2];
	////////////////////////////////////////////////////////////////////////
	// Register port decode
	assign go_req    = ce_i & sfr_wr_i & (sfr_addr_i == `TBM_ADR_CTRL)
		& sfr_wdata_i[`TBM_CTRL_GO_BIT] & ~go_busy_ff;
	// Loads during a frame would corrupt bytes in flight, so they are dropped
	assign wr_ok     = ce_i & sfr_wr_i & ~go_busy_ff;
	assign is_read   = peer_address_reg_ff[`TBM_PEER_DIR_BIT];
	assign last_byte = (byte_idx_ff == (two_byte_select_ff ? 2'd2 : 2'd1));
	assign byte_end  = tick & (state_ff == TBM_DATA) & (bit_idx_ff == `TBM_LAST_BIT);
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			peer_address_reg_ff  <= `TBM_RST_BYTE;
			primary_tx_byte_ff   <= `TBM_RST_BYTE;
			secondary_tx_byte_ff <= `TBM_RST_BYTE;
			two_byte_select_ff   <= 1'b0;
		end else if (wr_ok) begin
			unique case (sfr_addr_i)
				`TBM_ADR_PEER:   peer_address_reg_ff  <= sfr_wdata_i;
				`TBM_ADR_TX_PRI: primary_tx_byte_ff   <= sfr_wdata_i;
				`TBM_ADR_TX_SEC: secondary_tx_byte_ff <= sfr_wdata_i;
				`TBM_ADR_CTRL:   two_byte_select_ff   <= sfr_wdata_i[`TBM_CTRL_TWO_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			transfer_done_irq_enable_ff <= 1'b0;
		end else if (ce_i & sfr_wr_i & (sfr_addr_i == `TBM_ADR_IRQ6)) begin
			transfer_done_irq_enable_ff <= sfr_wdata_i[`TBM_IRQ6_EN_BIT];
		end
	end
	// Registered read data, one cycle after the read strobe
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sfr_rdata_o <= `TBM_RST_BYTE;
		end else if (ce_i & sfr_rd_i) begin
			unique case (sfr_addr_i)
				`TBM_ADR_PEER:   sfr_rdata_o <= peer_address_reg_ff;
				`TBM_ADR_TX_PRI: sfr_rdata_o <= primary_tx_byte_ff;
				`TBM_ADR_TX_SEC: sfr_rdata_o <= secondary_tx_byte_ff;
				`TBM_ADR_RX_PRI: sfr_rdata_o <= primary_rx_byte_ff;
				`TBM_ADR_RX_SEC: sfr_rdata_o <= secondary_rx_byte_ff;
				`TBM_ADR_CTRL:   sfr_rdata_o <= {5'h00, ack_error_flag_ff, go_busy_ff,
					two_byte_select_ff};
				`TBM_ADR_IRQ6:   sfr_rdata_o <= {4'h0, transfer_done_irq_enable_ff,
					transfer_done_flag_ff, 2'h0};
				default:         sfr_rdata_o <= `TBM_RST_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer, advanced once per 400 kHz slot
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_ff    <= TBM_IDLE;
			bit_idx_ff  <= 4'h0;
			byte_idx_ff <= 2'h0;
		end else if (ce_i) begin
			unique case (state_ff)
				TBM_IDLE: if (go_req) state_ff <= TBM_ARM;
				TBM_ARM: if (tick) state_ff <= TBM_START;
				TBM_START: if (tick) begin
					state_ff    <= TBM_DATA;
					bit_idx_ff  <= 4'h0;
					byte_idx_ff <= 2'h0;
				end
				TBM_DATA: if (tick) begin
					if (bit_idx_ff != `TBM_LAST_BIT) begin
						bit_idx_ff <= bit_idx_ff + 4'h1;
					end else if (last_byte | nack_seen) begin
						state_ff <= TBM_STOP;
					end else begin
						bit_idx_ff  <= 4'h0;
						byte_idx_ff <= byte_idx_ff + 2'h1;
					end
				end
				TBM_STOP: if (tick) state_ff <= TBM_IDLE;
				default: state_ff <= TBM_IDLE;
			endcase
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ph_ff <= 7'h7f;
		end else if (ce_i) begin
			if (tick) begin
				ph_ff <= 7'h00;
			end else if (ph_ff != 7'h7f) begin
				ph_ff <= ph_ff + 7'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status: busy, acknowledge error, completion flag
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			go_busy_ff <= 1'b0;
		end else if (ce_i) begin
			if (go_req) begin
				go_busy_ff <= 1'b1;
			end else if (tick & (state_ff == TBM_STOP)) begin
				go_busy_ff <= 1'b0;
			end
		end
	end
	// Ack slot of the address byte, or of any written byte
	assign nack_seen = ack_error_flag_ff;
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_error_flag_ff <= 1'b0;
		end else if (ce_i) begin
			if (go_req) begin
				ack_error_flag_ff <= 1'b0;
			end else if ((state_ff == TBM_DATA) & (bit_idx_ff == `TBM_LAST_BIT)
				& (ph_ff == SAMPLE) & (~is_read | (byte_idx_ff == 2'd0))
				& sda_sync_ff[1]) begin
				ack_error_flag_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			transfer_done_flag_ff <= 1'b0;
		end else if (ce_i) begin
			if (tick & (state_ff == TBM_STOP)) begin
				transfer_done_flag_ff <= 1'b1;
			end else if (go_req) begin
				transfer_done_flag_ff <= 1'b0;
			end
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq6_o <= 1'b0;
		end else if (ce_i) begin
			irq6_o <= transfer_done_flag_ff & transfer_done_irq_enable_ff;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Receive path
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rx_sh_ff             <= `TBM_RST_BYTE;
			primary_rx_byte_ff   <= `TBM_RST_BYTE;
			secondary_rx_byte_ff <= `TBM_RST_BYTE;
		end else if (ce_i) begin
			if ((state_ff == TBM_DATA) & (ph_ff == SAMPLE) & (bit_idx_ff != `TBM_LAST_BIT)) begin
				rx_sh_ff <= {rx_sh_ff[6:0], sda_sync_ff[1]};
			end
			if (byte_end & is_read & (byte_idx_ff == 2'd1)) begin
				primary_rx_byte_ff <= rx_sh_ff;
			end
			if (byte_end & is_read & (byte_idx_ff == 2'd2)) begin
				secondary_rx_byte_ff <= rx_sh_ff;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Pad drive; the serial clock is only ever pulled low, never driven high
	always_comb begin
		unique case (byte_idx_ff)
			2'd0:    cur_tx = peer_address_reg_ff;
			2'd1:    cur_tx = primary_tx_byte_ff;
			default: cur_tx = secondary_tx_byte_ff;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (ce_i) begin
			unique case (state_ff)
				TBM_START: begin
					scl_oe_o <= 1'b0;
					sda_oe_o <= (ph_ff >= HALF);
				end
				TBM_DATA: begin
					scl_oe_o <= (ph_ff < HALF);
					if (ph_ff == SDA_SET) begin
						if (bit_idx_ff == `TBM_LAST_BIT) begin
							sda_oe_o <= is_read & (byte_idx_ff != 2'd0) & ~last_byte;
						end else if (is_read & (byte_idx_ff != 2'd0)) begin
							sda_oe_o <= 1'b0;
						end else begin
							sda_oe_o <= ~cur_tx[3'(7 - bit_idx_ff)];
						end
					end
				end
				TBM_STOP: begin
					scl_oe_o <= (ph_ff < HALF);
					if (ph_ff == SDA_SET) begin
						sda_oe_o <= 1'b1;
					end else if (ph_ff == SAMPLE) begin
						sda_oe_o <= 1'b0;
					end
				end
				default: begin
					scl_oe_o <= 1'b0;
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Checks
	a_done_at_stop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ce_i & tick & (state_ff == TBM_STOP)) |=> (transfer_done_flag_ff & ~go_busy_ff))
		else $error("done flag or busy wrong after stop");
	a_start_clears: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		go_req |=> (~transfer_done_flag_ff & ~ack_error_flag_ff & go_busy_ff))
		else $error("start did not clear status");
	a_irq_masked: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ce_i & ~transfer_done_irq_enable_ff) |=> ~irq6_o)
		else $error("interrupt seen while masked");
	a_idle_release: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(state_ff == TBM_IDLE)[*2] |-> (~scl_oe_o & ~sda_oe_o))
		else $error("bus driven while idle");
	a_start_cond: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		((state_ff == TBM_START) & (ph_ff == 7'd60)) |-> (~scl_oe_o & sda_oe_o))
		else $error("start condition wrong");
	a_scl_low_half: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		((state_ff == TBM_DATA) & (ph_ff > 7'd1) & (ph_ff < 7'd40)) |-> scl_oe_o)
		else $error("serial clock not low in first half");
	a_nack_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ce_i & (state_ff == TBM_DATA) & (bit_idx_ff == 4'd8) & (ph_ff == SAMPLE)
		& ~is_read & sda_sync_ff[1]) |=> ack_error_flag_ff)
		else $error("missed acknowledge error");
	a_rx_second: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ce_i & byte_end & is_read & (byte_idx_ff == 2'd2))
		|=> (secondary_rx_byte_ff == $past(rx_sh_ff)))
		else $error("second byte not captured");
	a_busy_lock: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(go_busy_ff & sfr_wr_i & (sfr_addr_i == `TBM_ADR_PEER))
		|=> $stable(peer_address_reg_ff))
		else $error("address changed while busy");
	a_slot_ends: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(ce_i & tick & (state_ff == TBM_ARM)) |=> ((state_ff == TBM_START) & (ph_ff == 7'h00)))
		else $error("frame did not open on time base edge");

endmodule

// file: verilog/tbm_consts.svh
// Constants of the two-byte serial bus master: offsets, fields, resets, timing.
// Assumes an 8-bit special function register port with 16-bit addresses.
`ifndef TBM_CONSTS_SVH
`define TBM_CONSTS_SVH

`define TBM_ADR_PEER        16'hff80
`define TBM_ADR_TX_PRI      16'hff81
`define TBM_ADR_TX_SEC      16'hff82
`define TBM_ADR_RX_PRI      16'hff83
`define TBM_ADR_RX_SEC      16'hff84
`define TBM_ADR_CTRL        16'hff85
`define TBM_ADR_IRQ6        16'hff95

`define TBM_RST_BYTE        8'h00

`define TBM_CTRL_TWO_BIT    0
`define TBM_CTRL_GO_BIT     1
`define TBM_CTRL_AERR_BIT   2
`define TBM_IRQ6_FLAG_BIT   2
`define TBM_IRQ6_EN_BIT     3
`define TBM_PEER_DIR_BIT    0

`define TBM_CLK_PERIOD_NS   25
`define TBM_SCL_PERIOD_NS   2500
`define TBM_SLOT_CYC        (`TBM_SCL_PERIOD_NS / `TBM_CLK_PERIOD_NS)
`define TBM_HALF_CYC        (`TBM_SLOT_CYC / 2)
`define TBM_SDA_SET_CYC     (`TBM_SLOT_CYC / 8)
`define TBM_SAMPLE_CYC      ((`TBM_SLOT_CYC * 3) / 4)
`define TBM_LAST_BIT        4'd8

`endif

// file: verilog/tbm_pkg.sv
// Types shared by the two-byte serial bus master.
// Constants live in tbm_consts.svh.
package tbm_pkg;
	typedef enum logic [2:0] {
		TBM_IDLE  = 3'b000,
		TBM_ARM   = 3'b001,
		TBM_START = 3'b010,
		TBM_DATA  = 3'b011,
		TBM_STOP  = 3'b100
	} tbm_state_e;
	typedef logic [7:0] tbm_byte_t;
endpackage

// file: tb/tbm_peer_model.sv
// Behavioural peer device on the two-wire bus: answers one address.
// Assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/100ps
module tbm_peer_model #(
	parameter logic [6:0] PEER = 7'h2a
) (
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       nack_i,
	input  wire logic [7:0] tx0_i,
	input  wire logic [7:0] tx1_i,
	output logic            sda_oe_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      b0_o,
	output logic [7:0]      b1_o,
	output logic [1:0]      nb_o,
	output logic [1:0]      mack_o
);
	int         cnt;
	int         nr;
	logic       act;
	logic       first;
	logic       rw;
	logic       hit;
	logic [7:0] sh;
	logic [7:0] tx;
	initial begin
		{act, first, rw, hit, sda_oe_o, nb_o, mack_o} = '0;
		{addr_o, b0_o, b1_o, sh, tx} = '0;
		cnt = 0;
		nr = 0;
	end
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			{act, first} = 2'b11;
			cnt = 0;
			nr = 0;
			nb_o = 2'h0;
			mack_o = 2'h0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b0;
			sda_oe_o = 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge scl_i) begin
		if (act) begin
			if (cnt < 8)
				sh = {sh[6:0], sda_i};
			else if (!first && rw) begin
				mack_o[nr] = sda_i;
				nr++;
			end
			cnt++;
		end
	end
	// Drive only while the clock is low, so data never moves under a high clock
	always @(negedge scl_i) begin
		if (act) begin
			if (cnt == 8) begin
				if (first) begin
					addr_o = sh;
					rw = sh[0];
					hit = (sh[7:1] == PEER);
					sda_oe_o = hit;
				end else if (!rw) begin
					if (nb_o == 0)
						b0_o = sh;
					else
						b1_o = sh;
					nb_o++;
					sda_oe_o = !nack_i;
				end else
					sda_oe_o = 1'b0;
			end else if (cnt == 9) begin
				cnt = 0;
				tx = (nr == 0) ? tx0_i : tx1_i;
				sda_oe_o = rw && hit && (first || !mack_o[nr-1]) && !tx[7];
				first = 1'b0;
			end else if (rw && !first)
				sda_oe_o = !tx[7-cnt];
		end
	end
endmodule

// file: tb/tb_two_byte_serial_bus_master.sv
// Self-checking bench for the two-byte serial bus master and its registers.
// Assumes tbm_consts.svh, tbm_pkg and the peer model are compiled first.
`timescale 1ns/100ps
`include "tbm_consts.svh"
module tb_two_byte_serial_bus_master;
	import tbm_pkg::*;
	typedef struct packed {
		logic [7:0] peer;
		logic       two;
		logic [7:0] b0;
		logic [7:0] b1;
		logic       nack;
		logic       aerr;
		logic [1:0] nb;
	} tbm_row_s;
	logic       core_clk;
	logic       rst_b;
	logic       ce;
	logic       wr;
	logic       rd;
	logic       tb400;
	logic       nack;
	logic       irq6;
	logic       scl_oe;
	logic       sda_oe;
	logic       scl_o_w;
	logic       sda_o_w;
	logic       s_oe;
	logic [15:0] addr;
	tbm_byte_t  wdata;
	tbm_byte_t  rdata;
	tbm_byte_t  tx0;
	tbm_byte_t  tx1;
	tbm_byte_t  got;
	tbm_byte_t  s_addr;
	tbm_byte_t  s_b0;
	tbm_byte_t  s_b1;
	logic [1:0] s_nb;
	logic [1:0] s_mack;
	logic [15:0] adrs[8];
	int         n_mismatch;
	int         samples_checked;
	wire scl_line = scl_oe ? scl_o_w : 1'b1;
	wire sda_line = (sda_oe ? sda_o_w : 1'b1) & ~s_oe;
	// Write, write two, read one, read two, wrong address, refused data byte
	tbm_row_s rows[6] = '{
		'{8'h54, 1'b0, 8'h81, 8'h00, 1'b0, 1'b0, 2'd1},
		'{8'h54, 1'b1, 8'h7e, 8'hc3, 1'b0, 1'b0, 2'd2},
		'{8'h55, 1'b0, 8'h96, 8'h00, 1'b0, 1'b0, 2'd0},
		'{8'h55, 1'b1, 8'h01, 8'h80, 1'b0, 1'b0, 2'd0},
		'{8'h56, 1'b0, 8'h33, 8'h00, 1'b0, 1'b1, 2'd0},
		'{8'h54, 1'b1, 8'h42, 8'h24, 1'b1, 1'b1, 2'd1}};
	////////////////////////////////////////////////////////////////////////////////
	tbm_master uut (.core_clk_i(core_clk), .rst_b_i(rst_b), .ce_i(ce), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .irq6_o(irq6), .tb_400k_i(tb400),
		.scl_i(scl_line), .scl_o(scl_o_w), .scl_oe_o(scl_oe), .sda_i(sda_line), .sda_o(sda_o_w), .sda_oe_o(sda_oe));
	tbm_peer_model peer (.scl_i(scl_line), .sda_i(sda_line), .nack_i(nack), .tx0_i(tx0), .tx1_i(tx1),
		.sda_oe_o(s_oe), .addr_o(s_addr), .b0_o(s_b0), .b1_o(s_b1), .nb_o(s_nb), .mack_o(s_mack));
	always #12.5 core_clk = ~core_clk;
	// Odd offset keeps the time base edges clear of the core clock edges
	initial begin
		tb400 = 1'b0;
		#7;
		forever #1250 tb400 = ~tb400;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(negedge core_clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge core_clk);
		wr = 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a);
		@(negedge core_clk);
		addr = a;
		rd = 1'b1;
		@(negedge core_clk);
		rd = 1'b0;
		got = rdata;
	endtask
	task automatic stop_test;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wait_idle;
		int i;
		for (i = 0; i < 3000; i++) begin
			rd_reg(`TBM_ADR_CTRL);
			if (got[1] === 1'b0)
				break;
		end
		if (i == 3000) begin
			n_mismatch++;
			$display("FAIL %0t busy never cleared", $time);
			stop_test();
		end
	endtask
	task automatic run(input tbm_row_s r, input logic en);
		tx0 = r.b0;
		tx1 = r.b1;
		nack = r.nack;
		wr_reg(`TBM_ADR_PEER, r.peer);
		wr_reg(`TBM_ADR_TX_PRI, r.b0);
		wr_reg(`TBM_ADR_TX_SEC, r.b1);
		wr_reg(`TBM_ADR_CTRL, {6'h0, 1'b1, r.two});
		rd_reg(`TBM_ADR_CTRL);
		chk(got, {6'h0, 1'b1, r.two}, "busy");
		chk({7'h0, irq6}, 8'h00, "irq drop");
		wait_idle();
		chk(got, {5'h0, r.aerr, 1'b0, r.two}, "status");
		rd_reg(`TBM_ADR_IRQ6);
		chk(got, {4'h0, en, 3'b100}, "flag");
		chk({7'h0, irq6}, {7'h0, en}, "irq");
		chk(s_addr, r.peer, "addr");
		if (!r.peer[0]) begin
			chk({6'h0, s_nb}, {6'h0, r.nb}, "count");
			if (r.nb > 0)
				chk(s_b0, r.b0, "tx0");
			if (r.nb == 2)
				chk(s_b1, r.b1, "tx1");
		end else begin
			rd_reg(`TBM_ADR_RX_PRI);
			chk(got, r.b0, "rx0");
			chk({6'h0, s_mack}, r.two ? 8'h02 : 8'h01, "acks");
			if (r.two) begin
				rd_reg(`TBM_ADR_RX_SEC);
				chk(got, r.b1, "rx1");
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{core_clk, rst_b, wr, rd, nack} = '0;
		ce = 1'b1;
		{addr, wdata, tx0, tx1} = '0;
		n_mismatch = 0;
		samples_checked = 0;
		adrs = '{`TBM_ADR_PEER, `TBM_ADR_TX_PRI, `TBM_ADR_TX_SEC, `TBM_ADR_RX_PRI,
			`TBM_ADR_RX_SEC, `TBM_ADR_CTRL, `TBM_ADR_IRQ6, 16'hff90};
		repeat (16) @(negedge core_clk);
		rst_b = 1'b1;
		chk({5'h0, irq6, scl_oe, sda_oe}, 8'h00, "reset pins");
		foreach (adrs[i]) begin
			rd_reg(adrs[i]);
			chk(got, `TBM_RST_BYTE, "reset reg");
		end
		wr_reg(`TBM_ADR_IRQ6, 8'h08);
		foreach (rows[i])
			run(rows[i], 1'b1);
		wr_reg(`TBM_ADR_IRQ6, 8'h00);
		run(rows[0], 1'b0);
		// Loads while busy and writes to read-only places must not land
		wr_reg(`TBM_ADR_TX_PRI, 8'h5a);
		wr_reg(`TBM_ADR_CTRL, 8'h02);
		wr_reg(`TBM_ADR_TX_PRI, 8'hff);
		wr_reg(`TBM_ADR_PEER, 8'h57);
		wr_reg(`TBM_ADR_RX_PRI, 8'hff);
		rd_reg(`TBM_ADR_PEER);
		chk(got, 8'h54, "peer kept");
		wait_idle();
		chk(s_b0, 8'h5a, "tx kept");
		rd_reg(`TBM_ADR_RX_PRI);
		chk(got, rows[3].b0, "rx read only");
		// Enable low must freeze the register file too
		ce = 1'b0;
		wr_reg(`TBM_ADR_TX_PRI, 8'h11);
		ce = 1'b1;
		rd_reg(`TBM_ADR_TX_PRI);
		chk(got, 8'h5a, "frozen write");
		// Reset in mid frame must let go of both lines at once
		wr_reg(`TBM_ADR_CTRL, 8'h02);
		repeat (300) @(negedge core_clk);
		rst_b = 1'b0;
		@(negedge core_clk);
		chk({5'h0, irq6, scl_oe, sda_oe}, 8'h00, "reset mid frame");
		rst_b = 1'b1;
		rd_reg(`TBM_ADR_CTRL);
		chk(got, `TBM_RST_BYTE, "busy after reset");
		stop_test();
	end
endmodule
